/* hw/cpau_arith.v */
`timescale 1ns/1ps
`default_nettype none
`include "cpau_consts.vh"
// arithmetic units of the central processor: one instruction at a time
module cpau_arith (
	input  wire        clk,
	input  wire        rst,
	input  wire        ce,
	input  wire        issue_valid,
	output wire        issue_ready,
	input  wire [5:0]  op_code,
	input  wire [2:0]  fld_i,
	input  wire [2:0]  fld_j,
	input  wire [2:0]  fld_k,
	input  wire [17:0] imm_k,
	output wire        instr_long,
	output reg         mem_req,
	output reg         mem_we,
	output reg  [17:0] mem_addr,
	output reg  [59:0] mem_wdata,
	input  wire [59:0] mem_rdata,
	input  wire        mem_ack,
	output reg         wb_valid,
	output reg  [1:0]  wb_dest,
	output reg  [2:0]  wb_index,
	output reg  [59:0] wb_data,
	output reg         done
);
	////////////////////////////////////////////////////////////////////
	// states
	localparam [1:0] ST_IDLE = 2'h0; // waiting for an instruction
	localparam [1:0] ST_EXEC = 2'h1; // operands read, result formed
	localparam [1:0] ST_MRD  = 2'h2; // fetching operand word to store
	localparam [1:0] ST_MREQ = 2'h3; // memory access outstanding

	reg  [1:0]  state_reg;     // sequencer state
	reg  [5:0]  op_reg;        // latched opcode
	reg  [2:0]  i_reg;         // destination index
	reg  [2:0]  j_reg;         // first source index
	reg  [2:0]  k_reg;         // second source index
	reg  [17:0] kc_reg;        // latched immediate constant
	reg  [17:0] a_reg [0:7];   // address registers
	reg  [17:0] b_reg [0:7];   // increment registers, b0 kept zero
	wire [59:0] xj;            // operand j from the register file
	wire [59:0] xk;            // operand k from the register file
	reg         x_we;          // register file write strobe
	reg  [2:0]  x_wa;          // register file write index
	reg  [59:0] x_wd;          // register file write data
	wire [2:0]  rd_addr0;      // read index j, or i ahead of a store
	integer     n;             // reset loop index

	////////////////////////////////////////////////////////////////////
	// helper functions

	// 18-bit ones-complement add with end-around carry
	function [17:0] oc18;
		input [17:0] a;
		input [17:0] b;
		reg   [18:0] s;
		begin
			s = {1'b0, a} + {1'b0, b};
			oc18 = s[17:0] + {17'h0, s[18]};
		end
	endfunction

	// 60-bit ones-complement add with end-around carry
	function [59:0] oc60;
		input [59:0] a;
		input [59:0] b;
		reg   [60:0] s;
		begin
			s = {1'b0, a} + {1'b0, b};
			oc60 = s[59:0] + {59'h0, s[60]};
		end
	endfunction

	// count of one bits in a word
	function [59:0] popcnt;
		input [59:0] w;
		integer      p;
		begin
			popcnt = 60'h0;
			for (p = 0; p < 60; p = p + 1)
				popcnt = popcnt + {59'h0, w[p]};
		end
	endfunction

	// exponent of a word, bias removed, after sign folding
	function [12:0] fexp;
		input [59:0] w;
		reg   [59:0] m;
		begin
			m = w[`CPAU_SIGN_BIT] ? ~w : w;
			fexp = {2'b00, m[`CPAU_EXP_HI:`CPAU_EXP_LO]} - `CPAU_EXP_BIAS;
		end
	endfunction

	// coefficient magnitude of a word
	function [47:0] fcoef;
		input [59:0] w;
		reg   [59:0] m;
		begin
			m = w[`CPAU_SIGN_BIT] ? ~w : w;
			fcoef = m[`CPAU_COEF_HI:0];
		end
	endfunction

	// repack sign, exponent and coefficient; no normalizing here
	function [59:0] fpack;
		input        neg;
		input [12:0] e;
		input [47:0] c;
		reg   [12:0] eb;
		reg   [59:0] w;
		begin
			eb = e + `CPAU_EXP_BIAS;
			w = {1'b0, eb[10:0], c};
			fpack = neg ? ~w : w;
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// issue side: ready only when idle, length decoded from the input
	assign issue_ready = (state_reg == ST_IDLE);
	// immediate forms are the first three of each short-arithmetic group
	assign instr_long = (op_code[5:3] >= `CPAU_GRP_A) && (op_code[2:0] <= 3'h2);

	// a store reads operand i through port 0 while sequencing to ST_MRD
	assign rd_addr0 = (state_reg == ST_IDLE) ? fld_j : i_reg;

	cpau_xfile #(
		.W  (60),
		.D  (8),
		.AW (3)
	) u_xfile (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.ra0 (rd_addr0),
		.ra1 (fld_k),
		.rd0 (xj),
		.rd1 (xk),
		.we  (x_we),
		.wa  (x_wa),
		.wd  (x_wd)
	);

	////////////////////////////////////////////////////////////////////
	// floating add and subtract datapath
	wire        f_sub   = (op_reg == `CPAU_OP_FDIF) || (op_reg == `CPAU_OP_DDIF)
	                   || (op_reg == `CPAU_OP_RDIF);
	wire        f_rnd   = (op_reg == `CPAU_OP_RSUM) || (op_reg == `CPAU_OP_RDIF);
	wire [12:0] ej      = fexp(xj);
	wire [12:0] ek      = fexp(xk);
	wire [47:0] cj      = fcoef(xj);
	wire [47:0] ck      = fcoef(xk);
	wire        sj      = xj[`CPAU_SIGN_BIT];
	wire        sk      = xk[`CPAU_SIGN_BIT] ^ f_sub;   // subtrahend sign turned
	wire        both_n  = cj[47] & ck[47];              // both normalized
	wire        j_big   = $signed(ej) >= $signed(ek);
	wire [12:0] e_big   = j_big ? ej : ek;
	wire [12:0] e_dif   = j_big ? (ej - ek) : (ek - ej);
	// round bit rides just below the coefficient in the lower half
	wire        rb_big  = f_rnd;
	wire        rb_sml  = f_rnd & (both_n | (sj ^ sk));
	wire [96:0] acc_big = {1'b0, (j_big ? cj : ck), rb_big, 47'h0};
	wire [96:0] acc_sml = {1'b0, (j_big ? ck : cj), rb_sml, 47'h0} >> e_dif;
	wire        neg_big = j_big ? sj : sk;
	wire        neg_sml = j_big ? sk : sj;
	wire [97:0] v_big   = neg_big ? (98'h0 - {1'b0, acc_big}) : {1'b0, acc_big};
	wire [97:0] v_sml   = neg_sml ? (98'h0 - {1'b0, acc_sml}) : {1'b0, acc_sml};
	wire [97:0] f_sum   = v_big + v_sml;
	wire        f_neg   = f_sum[97];
	wire [97:0] f_mag   = f_neg ? (98'h0 - f_sum) : f_sum;
	wire        f_ovf   = f_mag[96];
	// overflow: one place right and one more on the exponent
	wire [95:0] f_acc   = f_ovf ? f_mag[96:1] : f_mag[95:0];
	wire [12:0] f_exp   = e_big + {12'h0, f_ovf};
	// upper half packed as is; equal exponents make this an integer op
	wire [59:0] f_up    = fpack(f_neg, f_exp, f_acc[95:48]);
	wire [59:0] f_lo    = fpack(f_neg, f_exp - `CPAU_DP_OFS, f_acc[47:0]);

	////////////////////////////////////////////////////////////////////
	// multiply datapath: j multiplier, k multiplicand
	wire        m_rnd   = (op_reg == `CPAU_OP_RMUL);
	wire        m_neg   = sj ^ xk[`CPAU_SIGN_BIT];
	wire [48:0] m_cand  = {ck, m_rnd};
	wire [96:0] m_prod  = cj * m_cand;
	wire [95:0] m_full  = m_prod[96:1];
	// normalized inputs leave at most one leading zero to remove
	wire        m_shl   = both_n & ~m_full[95];
	wire [95:0] m_adj   = m_shl ? {m_full[94:0], 1'b0} : m_full;
	wire [12:0] m_esum  = ej + ek;
	wire [12:0] m_exp   = m_esum + (m_shl ? `CPAU_NORM_OFS : `CPAU_DP_OFS);
	wire [59:0] m_up    = fpack(m_neg, m_exp, m_adj[95:48]);
	wire [59:0] m_lo    = fpack(m_neg, m_esum, m_full[47:0]);

	////////////////////////////////////////////////////////////////////
	// divide datapath: j dividend, k divisor
	wire [95:0] d_dvd   = {cj, ((op_reg == `CPAU_OP_RDIV) ? `CPAU_THIRD : 48'h0)};
	// zero divisor gives an all-ones quotient rather than an undefined one
	wire [95:0] d_quo   = (ck == 48'h0) ? {96{1'b1}} : (d_dvd / {48'h0, ck});
	wire        d_ovf   = d_quo[48];
	wire [47:0] d_coef  = d_ovf ? d_quo[48:1] : d_quo[47:0];
	wire [12:0] d_exp   = ej - ek - (d_ovf ? `CPAU_NORM_OFS : `CPAU_DP_OFS);
	wire [59:0] d_res   = fpack(m_neg, d_exp, d_coef);

	////////////////////////////////////////////////////////////////////
	// integer, mask and short arithmetic
	wire [59:0] i_sum   = oc60(xj, xk);
	wire [59:0] i_dif   = oc60(xj, ~xk);
	wire [5:0]  six_bit_count_field = {j_reg, k_reg};
	// a count above 60 simply fills the whole word
	wire [59:0] mask_w  = ~({60{1'b1}} >> six_bit_count_field);
	wire [2:0]  s_sel   = op_reg[2:0];
	wire [17:0] s_opa   = (s_sel == 3'h0 || s_sel == 3'h4 || s_sel == 3'h5) ? a_reg[j_reg] :
	                      (s_sel == 3'h2 || s_sel == 3'h3) ? xj[17:0] : b_reg[j_reg];
	wire [17:0] s_opb   = (s_sel <= 3'h2) ? kc_reg : b_reg[k_reg];
	wire        s_sub   = (s_sel == 3'h5) || (s_sel == 3'h7);
	wire [17:0] s_res   = oc18(s_opa, s_sub ? ~s_opb : s_opb);

	////////////////////////////////////////////////////////////////////
	// result selection for the operand register file
	reg  [59:0] x_res;  // value bound for operand register i
	reg         x_hit;  // the opcode writes operand register i
	always @*
	begin
		x_hit = 1'b1;
		x_res = `CPAU_RST_WORD;
		case (op_reg)
			`CPAU_OP_FSUM, `CPAU_OP_FDIF, `CPAU_OP_RSUM, `CPAU_OP_RDIF:
				x_res = f_up;
			`CPAU_OP_DSUM, `CPAU_OP_DDIF:
				x_res = f_lo;
			`CPAU_OP_ISUM:
				x_res = i_sum;
			`CPAU_OP_IDIF:
				x_res = i_dif;
			`CPAU_OP_FMUL, `CPAU_OP_RMUL:
				x_res = m_up;
			`CPAU_OP_DMUL:
				x_res = m_lo;
			`CPAU_OP_MASK:
				x_res = mask_w;
			`CPAU_OP_FDIV, `CPAU_OP_RDIV:
				x_res = d_res;
			`CPAU_OP_POP:
				x_res = popcnt(xk);
			default:
			begin
				// short results into X carry the sign up the word
				x_hit = (op_reg[5:3] == `CPAU_GRP_X);
				x_res = {{42{s_res[17]}}, s_res};
			end
		endcase
		// the pass opcode, and anything outside this block but group X, write no operand register
		if (op_reg == `CPAU_OP_PASS)
			x_hit = 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// register file write: results in execute, loaded words on ack
	wire load_ack = (state_reg == ST_MREQ) && mem_ack && !mem_we;
	always @*
	begin
		x_we = 1'b0;
		x_wa = i_reg;
		x_wd = x_res;
		if (state_reg == ST_EXEC && x_hit)
			x_we = 1'b1;
		else if (load_ack)
		begin
			x_we = 1'b1;
			x_wd = mem_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// sequencer, address and increment registers, memory and write-back
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= ST_IDLE;
			op_reg    <= 6'h0;
			i_reg     <= 3'h0;
			j_reg     <= 3'h0;
			k_reg     <= 3'h0;
			kc_reg    <= `CPAU_RST_SHORT;
			mem_req   <= 1'b0;
			mem_we    <= 1'b0;
			mem_addr  <= `CPAU_RST_SHORT;
			mem_wdata <= `CPAU_RST_WORD;
			wb_valid  <= 1'b0;
			wb_dest   <= `CPAU_DST_X;
			wb_index  <= 3'h0;
			wb_data   <= `CPAU_RST_WORD;
			done      <= 1'b0;
			for (n = 0; n < 8; n = n + 1)
			begin
				a_reg[n] <= `CPAU_RST_SHORT;
				b_reg[n] <= `CPAU_RST_SHORT;
			end
		end
		else if (ce)
		begin
			wb_valid <= 1'b0;
			done     <= 1'b0;
			case (state_reg)
				ST_IDLE:
				begin
					// operands are read in this same cycle
					if (issue_valid)
					begin
						op_reg    <= op_code;
						i_reg     <= fld_i;
						j_reg     <= fld_j;
						k_reg     <= fld_k;
						kc_reg    <= imm_k;
						state_reg <= ST_EXEC;
					end
				end
				ST_EXEC:
				begin
					state_reg <= ST_IDLE;
					done      <= 1'b1;
					if (x_hit)
					begin
						wb_valid <= 1'b1;
						wb_dest  <= `CPAU_DST_X;
						wb_index <= i_reg;
						wb_data  <= x_res;
					end
					else if (op_reg[5:3] == `CPAU_GRP_A)
					begin
						a_reg[i_reg] <= s_res;
						wb_valid     <= 1'b1;
						wb_dest      <= `CPAU_DST_A;
						wb_index     <= i_reg;
						wb_data      <= {42'h0, s_res};
						mem_addr     <= s_res;
						// a0 has no memory partner
						if (i_reg >= 3'h6)
						begin
							state_reg <= ST_MRD;
							done      <= 1'b0;
						end
						else if (i_reg != 3'h0)
						begin
							mem_req   <= 1'b1;
							mem_we    <= 1'b0;
							state_reg <= ST_MREQ;
							done      <= 1'b0;
						end
					end
					else if (op_reg[5:3] == `CPAU_GRP_B)
					begin
						// b0 stays zero so constant forms keep their meaning
						if (i_reg != 3'h0)
							b_reg[i_reg] <= s_res;
						wb_valid <= (i_reg != 3'h0);
						wb_dest  <= `CPAU_DST_B;
						wb_index <= i_reg;
						wb_data  <= {42'h0, s_res};
					end
				end
				ST_MRD:
				begin
					// operand i is on read port 0 now
					mem_wdata <= xj;
					mem_req   <= 1'b1;
					mem_we    <= 1'b1;
					state_reg <= ST_MREQ;
				end
				ST_MREQ:
				begin
					// request stands until memory answers
					if (mem_ack)
					begin
						mem_req   <= 1'b0;
						mem_we    <= 1'b0;
						state_reg <= ST_IDLE;
						done      <= 1'b1;
						if (!mem_we)
						begin
							wb_valid <= 1'b1;
							wb_dest  <= `CPAU_DST_X;
							wb_index <= i_reg;
							wb_data  <= mem_rdata;
						end
					end
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule // cpau_arith
`default_nettype wire

/* hw/cpau_consts.vh */
// Behaviour
// - float sum aligns smaller coefficient in 96-bit accumulator
// - coefficient overflow shifts right, exponent plus one
// - upper half repacked, never normalized
// - zero exponents, no overflow: plain integer add
// - float difference aligns like sum, equal exponents subtract
// - double-precision forms pack lower half, exponent minus 48
// - rounded sum: both rounded if normalized or unlike
// - rounded difference: both rounded if normalized or alike
// - 60-bit ones-complement integer sum, overflow ignored
// - 60-bit ones-complement integer difference j minus k
// - float product upper half, exponent sum plus 47/48
// - rounded product rounds multiplicand, upper half only
// - double-precision product packs lower product half
// - mask of ones from top, count field, zero gives zero
// - divide exponent minus 48, overflow shift minus 47
// - rounded divide adds one-third bit to dividend
// - population count of k written to i
// - opcodes 50-57 do 18-bit ones-complement into address
// - immediate forms 30 bits, register forms 15 bits
// - address registers 1-5 load operand register from memory
// - address registers 6-7 store operand register to memory
// - opcodes 60-67 same arithmetic into increment register
// - 18-bit result into operand register is sign extended
`ifndef CPAU_CONSTS_VH
`define CPAU_CONSTS_VH
// opcodes handled one by one
`define CPAU_OP_FSUM   6'h18
`define CPAU_OP_FDIF   6'h19
`define CPAU_OP_DSUM   6'h1a
`define CPAU_OP_DDIF   6'h1b
`define CPAU_OP_RSUM   6'h1c
`define CPAU_OP_RDIF   6'h1d
`define CPAU_OP_ISUM   6'h1e
`define CPAU_OP_IDIF   6'h1f
`define CPAU_OP_FMUL   6'h20
`define CPAU_OP_RMUL   6'h21
`define CPAU_OP_DMUL   6'h22
`define CPAU_OP_MASK   6'h23
`define CPAU_OP_FDIV   6'h24
`define CPAU_OP_RDIV   6'h25
`define CPAU_OP_PASS   6'h26
`define CPAU_OP_POP    6'h27
// upper opcode digit of the short-arithmetic groups
`define CPAU_GRP_A     3'h5
`define CPAU_GRP_B     3'h6
`define CPAU_GRP_X     3'h7
// floating word layout
`define CPAU_SIGN_BIT  59
`define CPAU_EXP_HI    58
`define CPAU_EXP_LO    48
`define CPAU_COEF_HI   47
// exponent constants, 13-bit signed arithmetic
`define CPAU_EXP_BIAS  13'h0400
`define CPAU_DP_OFS    13'h0030
`define CPAU_NORM_OFS  13'h002f
// one-third round pattern below the dividend
`define CPAU_THIRD     48'h555555555555
// reset value of the 60-bit and 18-bit data registers outside the operand register file
`define CPAU_RST_WORD  60'h0
`define CPAU_RST_SHORT 18'h0
// write-back destination codes
`define CPAU_DST_X     2'h0
`define CPAU_DST_A     2'h1
`define CPAU_DST_B     2'h2
`endif

/* hw/cpau_xfile.v */
`timescale 1ns/1ps
`default_nettype none
// operand register file: two registered read ports, one write port
module cpau_xfile #(
	parameter W  = 60,
	parameter D  = 8,
	parameter AW = 3
) (
	input  wire          clk,
	input  wire          rst,
	input  wire          ce,
	input  wire [AW-1:0] ra0,
	input  wire [AW-1:0] ra1,
	output reg  [W-1:0]  rd0,
	output reg  [W-1:0]  rd1,
	input  wire          we,
	input  wire [AW-1:0] wa,
	input  wire [W-1:0]  wd
);
	reg [W-1:0] mem [0:D-1]; // storage words, contents undefined at reset

	// write port; frozen with the clock enable
	always @(posedge clk)
	begin
		if (ce && we)
			mem[wa] <= wd;
	end

	// read data leave through registers, one cycle after the address
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rd0 <= {W{1'b0}};
			rd1 <= {W{1'b0}};
		end
		else if (ce)
		begin
			rd0 <= mem[ra0];
			rd1 <= mem[ra1];
		end
	end
endmodule // cpau_xfile
`default_nettype wire

/* verification/cpau_arith_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the arithmetic block from its ports only
module cpau_arith_checker (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic        issue_valid,
	input wire logic        issue_ready,
	input wire logic [5:0]  op_code,
	input wire logic [2:0]  fld_i,
	input wire logic [2:0]  fld_j,
	input wire logic [2:0]  fld_k,
	input wire logic [17:0] imm_k,
	input wire logic        instr_long,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [17:0] mem_addr,
	input wire logic [59:0] mem_wdata,
	input wire logic [59:0] mem_rdata,
	input wire logic        mem_ack,
	input wire logic        wb_valid,
	input wire logic [1:0]  wb_dest,
	input wire logic [2:0]  wb_index,
	input wire logic [59:0] wb_data,
	input wire logic        done
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// an instruction accepted at this edge
	wire logic taken = ce && issue_valid && issue_ready;
	////////////////////////////////////////////////////////////////////////////////
	a_long_form: assert property (instr_long == (op_code[5:3] >= 3'h5 && op_code[2:0] <= 3'h2))
		else $error("instruction length wrong");
	a_busy_after: assert property (taken |=> !issue_ready)
		else $error("ready while busy");
	a_done_two: assert property (taken && op_code[5:3] != 3'h5 |-> ##2 done)
		else $error("done late");
	a_x_write: assert property (taken && op_code >= 6'h18 && op_code <= 6'h27 && op_code != 6'h26
		|-> ##2 wb_valid && wb_dest == 2'h0 && wb_index == $past(fld_i, 2))
		else $error("operand write missing");
	a_pass_quiet: assert property (taken && op_code == 6'h26 |-> ##2 done && !wb_valid)
		else $error("pass wrote a register");
	a_mask_ones: assert property (taken && op_code == 6'h23 && {fld_j, fld_k} <= 6'h3c
		|-> ##2 wb_data == ~(60'hfffffffffffffff >> $past({fld_j, fld_k}, 2)))
		else $error("mask wrong");
	a_b0_kept: assert property (taken && op_code[5:3] == 3'h6 && fld_i == 3'h0
		|-> ##2 done && !wb_valid)
		else $error("increment zero written");
	a_short_sext: assert property (taken && op_code[5:3] == 3'h7
		|-> ##2 wb_data[59:18] == {42{wb_data[17]}})
		else $error("short result not sign extended");
	a_load_start: assert property (taken && op_code[5:3] == 3'h5 && fld_i != 3'h0 && fld_i <= 3'h5
		|-> ##2 mem_req && !mem_we)
		else $error("load not started");
	a_store_start: assert property (taken && op_code[5:3] == 3'h5 && fld_i >= 3'h6
		|-> ##3 mem_req && mem_we)
		else $error("store not started");
	a_req_held: assert property (mem_req && !mem_ack
		|=> mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("request dropped early");
	a_load_back: assert property (mem_req && mem_ack && !mem_we
		|=> done && !mem_req && wb_valid && wb_dest == 2'h0 && wb_data == $past(mem_rdata))
		else $error("load data not written");
	a_store_quiet: assert property (mem_req && mem_ack && mem_we |=> done && !mem_req && !wb_valid)
		else $error("store end wrong");
endmodule // cpau_arith_checker

bind cpau_arith cpau_arith_checker i_chk (.clk(clk), .rst(rst), .ce(ce),
	.issue_valid(issue_valid), .issue_ready(issue_ready), .op_code(op_code),
	.fld_i(fld_i), .fld_j(fld_j), .fld_k(fld_k), .imm_k(imm_k), .instr_long(instr_long),
	.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
	.mem_rdata(mem_rdata), .mem_ack(mem_ack), .wb_valid(wb_valid), .wb_dest(wb_dest),
	.wb_index(wb_index), .wb_data(wb_data), .done(done));
`default_nettype wire

/* verification/cpau_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// central memory stand-in: one access per request, wait set by the bench
module cpau_mem_model (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [17:0] mem_addr,
	input wire logic [59:0] mem_wdata,
	output var logic [59:0] mem_rdata,
	output var logic        mem_ack
);
	logic [59:0] store [0:255]; // only the low address byte decodes
	int          wait_n = 0;    // cycles of delay before answering
	int          cnt;           // cycles waited so far
	////////////////////////////////////////////////////////////////////////////////
	// answer a held request; read data is garbage outside the ack cycle
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mem_ack   <= 1'b0;
			mem_rdata <= 60'h0;
			cnt       <= 0;
		end
		else if (mem_req && !mem_ack && cnt >= wait_n)
		begin
			mem_ack <= 1'b1;
			cnt     <= 0;
			if (mem_we)
				store[mem_addr[7:0]] <= mem_wdata;
			else
				mem_rdata <= store[mem_addr[7:0]];
		end
		else
		begin
			// toggling keeps a late sample from seeing valid data
			mem_ack   <= 1'b0;
			mem_rdata <= ~mem_rdata;
			cnt       <= (mem_req && !mem_ack) ? cnt + 1 : 0;
		end
	end
endmodule // cpau_mem_model
`default_nettype wire

/* verification/test_cpau_arith.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpau_consts.vh"
module test_cpau_arith;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic        issue_valid = 1'b0;
	logic [5:0]  op_code = 6'h0;
	logic [2:0]  fld_i = 3'h0;
	logic [2:0]  fld_j = 3'h0;
	logic [2:0]  fld_k = 3'h0;
	logic [17:0] imm_k = 18'h0;
	wire logic   issue_ready, instr_long, mem_req, mem_we, mem_ack, wb_valid, done;
	wire logic [17:0] mem_addr;
	wire logic [59:0] mem_wdata, mem_rdata, wb_data;
	wire logic [1:0]  wb_dest;
	wire logic [2:0]  wb_index;
	logic        c_valid;          // write-back seen at done
	logic [1:0]  c_dest;
	logic [2:0]  c_index;
	logic [59:0] c_data;
	int          bad_count = 0;
	int          compares = 0;
	always #10 clk = ~clk;
	cpau_arith i_dut (.clk(clk), .rst(rst), .ce(ce), .issue_valid(issue_valid),
		.issue_ready(issue_ready), .op_code(op_code), .fld_i(fld_i), .fld_j(fld_j),
		.fld_k(fld_k), .imm_k(imm_k), .instr_long(instr_long), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack), .wb_valid(wb_valid), .wb_dest(wb_dest), .wb_index(wb_index),
		.wb_data(wb_data), .done(done));
	cpau_mem_model i_mem (.clk(clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [59:0] got, input logic [59:0] exp);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// issue one instruction, hold it over the accepting edge, wait for done
	task run(input logic [5:0] op, input logic [2:0] i, input logic [2:0] j,
		input logic [2:0] k, input logic [17:0] imm);
		int n;
		op_code     = op;
		fld_i       = i;
		fld_j       = j;
		fld_k       = k;
		imm_k       = imm;
		issue_valid = 1'b1;
		@(posedge clk);
		chk({59'h0, instr_long}, {59'h0, op[5:3] >= 3'h5 && op[2:0] <= 3'h2});
		#1 issue_valid = 1'b0;
		for (n = 0; n < 60 && done !== 1'b1; n++)
			@(posedge clk) #1;
		if (done !== 1'b1)
			chk(60'h0, 60'h1);
		c_valid = wb_valid;
		c_dest  = wb_dest;
		c_index = wb_index;
		c_data  = wb_data;
	endtask
	// expect an operand register write of value v into index i
	task wbx(input logic [2:0] i, input logic [59:0] v);
		chk({54'h0, c_valid, c_dest, c_index}, {54'h0, 1'b1, 2'h0, i});
		chk(c_data, v);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// fill operands through address loads, memory prompt and slow
	task t_load;
		logic [59:0] xv [1:5];
		xv[1] = {1'b0, 11'h400, 48'h3};
		xv[2] = {1'b0, 11'h400, 48'h5};
		xv[3] = 60'h7;
		xv[4] = ~60'hf;
		xv[5] = 60'h0f0f0f0f0f0f0f0;
		for (int i = 1; i <= 5; i++)
		begin
			i_mem.store[8'h10 + i] = xv[i];
			i_mem.wait_n = i - 1;
			run(6'h28, i[2:0], 3'h0, 3'h0, 18'h10 + i[17:0]);
			chk({42'h0, mem_addr}, 60'h10 + i);
			wbx(i[2:0], xv[i]);
		end
	endtask
	// floating forms on zero-exponent unnormalized operands
	task t_float;
		run(`CPAU_OP_FDIF, 3'h0, 3'h2, 3'h1, 18'h0);
		wbx(3'h0, {1'b0, 11'h400, 48'h2});
		run(`CPAU_OP_DSUM, 3'h0, 3'h1, 3'h2, 18'h0);
		wbx(3'h0, {1'b0, 11'h3d0, 48'h0});
		run(`CPAU_OP_RSUM, 3'h0, 3'h1, 3'h2, 18'h0);
		wbx(3'h0, {1'b0, 11'h400, 48'h8});
		run(`CPAU_OP_RDIF, 3'h0, 3'h2, 3'h1, 18'h0);
		wbx(3'h0, {1'b0, 11'h400, 48'h2});
		run(`CPAU_OP_FMUL, 3'h0, 3'h1, 3'h2, 18'h0);
		wbx(3'h0, {1'b0, 11'h430, 48'h0});
		run(`CPAU_OP_DMUL, 3'h0, 3'h1, 3'h2, 18'h0);
		wbx(3'h0, {1'b0, 11'h400, 48'hf});
		run(`CPAU_OP_FSUM, 3'h6, 3'h1, 3'h2, 18'h0);
		wbx(3'h6, {1'b0, 11'h400, 48'h8});
	endtask
	// integer arithmetic, mask and population count
	task t_int;
		run(`CPAU_OP_ISUM, 3'h0, 3'h3, 3'h4, 18'h0);
		wbx(3'h0, ~60'h8);
		run(`CPAU_OP_IDIF, 3'h0, 3'h3, 3'h4, 18'h0);
		wbx(3'h0, 60'h16);
		run(`CPAU_OP_MASK, 3'h0, 3'h0, 3'h0, 18'h0);
		wbx(3'h0, 60'h0);
		run(`CPAU_OP_MASK, 3'h0, 3'h0, 3'h1, 18'h0);
		wbx(3'h0, {1'b1, 59'h0});
		run(`CPAU_OP_MASK, 3'h0, 3'h7, 3'h4, 18'h0);
		wbx(3'h0, ~60'h0);
		run(`CPAU_OP_POP, 3'h0, 3'h0, 3'h5, 18'h0);
		wbx(3'h0, 60'h1c);
		run(`CPAU_OP_POP, 3'h0, 3'h0, 3'h4, 18'h0);
		wbx(3'h0, 60'h38);
	endtask
	// short arithmetic, refused writes and a store through address six
	task t_short;
		run(6'h31, 3'h1, 3'h0, 3'h0, 18'h5);
		chk({54'h0, c_valid, c_dest, c_index}, {54'h0, 1'b1, 2'h2, 3'h1});
		chk(c_data, 60'h5);
		run(6'h3f, 3'h7, 3'h0, 3'h1, 18'h0);
		wbx(3'h7, ~60'h5);
		run(6'h30, 3'h0, 3'h0, 3'h0, 18'h9);
		chk({59'h0, c_valid}, 60'h0);
		run(`CPAU_OP_PASS, 3'h2, 3'h1, 3'h2, 18'h0);
		chk({59'h0, c_valid}, 60'h0);
		i_mem.wait_n = 2;
		run(6'h2f, 3'h6, 3'h0, 3'h1, 18'h0);
		chk({59'h0, c_valid}, 60'h0);
		chk(i_mem.store[8'hfa], {1'b0, 11'h400, 48'h8});
	endtask
	// normalized operands: alignment, overflow, rounded product, divide
	task t_fp;
		logic [59:0] fv [1:4];
		fv[1] = {1'b0, 11'h401, 48'h800000000000};
		fv[2] = {1'b0, 11'h400, 48'h800000000000};
		fv[3] = {1'b0, 11'h400, 48'hc00000000000};
		fv[4] = {1'b0, 11'h400, 48'hc00000000001};
		i_mem.wait_n = 0;
		for (int i = 1; i <= 4; i++)
		begin
			i_mem.store[8'h20 + i] = fv[i];
			run(6'h28, i[2:0], 3'h0, 3'h0, 18'h20 + i[17:0]);
			wbx(i[2:0], fv[i]);
		end
		run(`CPAU_OP_FSUM, 3'h5, 3'h1, 3'h2, 18'h0);
		wbx(3'h5, {1'b0, 11'h401, 48'hc00000000000});
		run(`CPAU_OP_FSUM, 3'h6, 3'h2, 3'h2, 18'h0);
		wbx(3'h6, {1'b0, 11'h401, 48'h800000000000});
		run(`CPAU_OP_FMUL, 3'h7, 3'h3, 3'h4, 18'h0);
		wbx(3'h7, {1'b0, 11'h430, 48'h900000000000});
		run(`CPAU_OP_RMUL, 3'h7, 3'h3, 3'h4, 18'h0);
		wbx(3'h7, {1'b0, 11'h430, 48'h900000000001});
		run(`CPAU_OP_FDIV, 3'h0, 3'h1, 3'h2, 18'h0);
		wbx(3'h0, {1'b0, 11'h3d2, 48'h800000000000});
		run(`CPAU_OP_FDIV, 3'h0, 3'h2, 3'h3, 18'h0);
		wbx(3'h0, {1'b0, 11'h3d0, 48'haaaaaaaaaaaa});
		run(`CPAU_OP_RDIV, 3'h0, 3'h2, 3'h3, 18'h0);
		wbx(3'h0, {1'b0, 11'h3d0, 48'haaaaaaaaaaab});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task summarize;
		if (bad_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// the whole run takes well under a thousand cycles
	initial
	begin
		#100000;
		bad_count++;
		summarize;
	end
	initial
	begin
		repeat (6) @(posedge clk);
		#1 rst = 1'b0;
		@(posedge clk) #1;
		t_load;
		t_float;
		t_int;
		t_short;
		t_fp;
		summarize;
	end
endmodule // test_cpau_arith
`default_nettype wire
